// ===== src/srp_pkg.sv
// Shared constants for the switch reset propagation block
package srp_pkg;
  localparam int NUM_DN_PORTS = 4;
  localparam int SYNC_STAGES = 2;
  // Bit positions of the control words
  localparam int SBR_BIT = 22;
  localparam int PROP_DIS_BIT = 20;
  localparam int DL_DOWN_LOAD_DIS_BIT = 16;
  localparam int HOT_LOAD_DIS_BIT = 17;
  // Least hot reset hold, in ns, and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOT_HOLD_NS = 2000;
  localparam int HOT_HOLD_CYC =
    (HOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    SRP_RUN, SRP_HOT, SRP_LOAD
  } srp_state_t;
endpackage

// ===== src/srp_rst_if.sv
// Carrier between the top module and the downstream port resetter
`timescale 1ns/100ps
interface srp_rst_if #(parameter int N = 4);
  logic core_rst_n;
  logic [N-1:0] port_hot;
  logic [N-1:0] port_reset;
  logic [N-1:0] port_drop;
  modport top (output core_rst_n, output port_hot,
    input port_reset, input port_drop);
  modport port (input core_rst_n, input port_hot,
    output port_reset, output port_drop);
endinterface

// ===== src/srp_port.sv
// Per downstream port hot reset holder
`timescale 1ns/100ps
module srp_port #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic ce,
  srp_rst_if.port rif
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_port
      always_ff @(posedge clk) begin
        if (!rif.core_rst_n) begin
          rif.port_reset[i] <= 1'b1;
          rif.port_drop[i] <= 1'b1;
        end else if (ce) begin
          // R17 held while request stands
          rif.port_reset[i] <= rif.port_hot[i];
          // R18 drain as on link inactive
          rif.port_drop[i] <= rif.port_hot[i];
        end
      end
    end
  endgenerate
endmodule

// ===== src/srp_top.sv
// Reset control for a multi-port packet switch
// Behaviour
// R1 - Fundamental reset reinitializes everything
// R2 - Warm reset treated as power-on reset
// R3 - Leaving reset restores all start-up values
// R4 - Hot reset discards all held packets
// R5 - Hot reset clears state, non-sticky bits
// R6 - Hot reset keeps clocks, config, sticky bits
// R7 - Upstream training reset bit starts hot reset
// R8 - Upstream link inactive acts as hot reset
// R9 - Hot reset forwarded via training reset bit
// R10 - Upstream bridge resets all secondary bridges
// R11 - Disable bit ignores upstream hot reset
// R12 - Disable bit blocks link-down internal reset
// R13 - Disable bit stops downstream hot reset
// R14 - Upstream bus reset resets downstream ports
// R15 - Upstream bus reset keeps upstream, drains
// R16 - Downstream bus reset resets only that port
// R17 - Port held in reset until bit cleared
// R18 - Drain reset port as link inactive
// R19 - Rerun configuration load after hot reset
// R20 - Synchronise fundamental reset release
`timescale 1ns/100ps
module srp_top #(
  parameter int NUM_DN = srp_pkg::NUM_DN_PORTS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic fundamental_reset_n,
  input wire logic up_rx_hot_reset,
  input wire logic up_dl_inactive,
  input wire logic cfg_mem_present,
  input wire logic [31:0] debug_control,
  input wire logic [31:0] up_bridge_control_word,
  input wire logic [NUM_DN-1:0] dn_sbr,
  output logic core_reset_n,
  output logic hot_reset_n,
  output logic up_queue_flush,
  output logic [NUM_DN-1:0] dn_tx_hot_reset,
  output logic [NUM_DN-1:0] dn_port_reset,
  output logic [NUM_DN-1:0] dn_queue_drop,
  output logic cfg_load_start,
  output logic busy
);
  // Port vector and pack logic serve 1 to 16 ports only
  if (NUM_DN < 1 || NUM_DN > 16) begin : g_bad_num_dn
    $error("NUM_DN out of range");
  end

  localparam int HW = $clog2(srp_pkg::HOT_HOLD_CYC + 1);

  logic [srp_pkg::SYNC_STAGES-1:0] sync;
  logic rst_ok;
  logic load_pend;
  logic prop_dis;
  logic up_sbr;
  logic up_event;
  logic up_event_q;
  logic up_dl_inactive_seen;
  logic [HW-1:0] hold_cnt;
  srp_pkg::srp_state_t state;
  srp_pkg::srp_state_t next_state;
  srp_rst_if #(.N(NUM_DN)) rif ();

  function automatic logic bit_of(input logic [31:0] w, input int pos);
    bit_of = w[pos];
  endfunction

  // R20 two-stage release synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n || !fundamental_reset_n) begin
      sync <= '0;
    end else begin
      sync <= {sync[srp_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_ok = sync[srp_pkg::SYNC_STAGES-1];

  assign prop_dis = bit_of(debug_control, srp_pkg::PROP_DIS_BIT);
  assign up_sbr = bit_of(up_bridge_control_word, srp_pkg::SBR_BIT);
  // R7 R8 upstream triggers, R11 R12 gated off
  assign up_event = !prop_dis && (up_rx_hot_reset || up_dl_inactive);

  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      up_event_q <= 1'b0;
    end else if (ce) begin
      up_event_q <= up_event;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      srp_pkg::SRP_RUN: begin
        if (up_event) begin
          next_state = srp_pkg::SRP_HOT;
        end
      end
      srp_pkg::SRP_HOT: begin
        if (!up_event && hold_cnt == '0) begin
          next_state = srp_pkg::SRP_LOAD;
        end
      end
      srp_pkg::SRP_LOAD: begin
        next_state = srp_pkg::SRP_RUN;
      end
    endcase
  end

  // R1 R2 R3 whole block restarts on fundamental reset
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      state <= srp_pkg::SRP_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Hold keeps a short glitch from giving a runt reset
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      hold_cnt <= '0;
    end else if (ce) begin
      if (up_event && !up_event_q) begin
        hold_cnt <= HW'(srp_pkg::HOT_HOLD_CYC);
      end else if (hold_cnt != '0) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
    end
  end

  // Load runs after fundamental release and after each hot reset
  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      load_pend <= 1'b1;
      cfg_load_start <= 1'b0;
    end else if (ce) begin
      cfg_load_start <= 1'b0;
      if (load_pend) begin
        load_pend <= 1'b0;
        cfg_load_start <= cfg_mem_present;
      end else if (next_state == srp_pkg::SRP_LOAD) begin
        // R19 reload unless disabled
        cfg_load_start <= cfg_mem_present &&
          !(up_dl_inactive_seen ? bit_of(debug_control,
            srp_pkg::DL_DOWN_LOAD_DIS_BIT) :
            bit_of(debug_control, srp_pkg::HOT_LOAD_DIS_BIT));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      up_dl_inactive_seen <= 1'b0;
    end else if (ce) begin
      if (state == srp_pkg::SRP_RUN && up_event) begin
        up_dl_inactive_seen <= up_dl_inactive && !up_rx_hot_reset;
      end
    end
  end

  // R10 R14 R16 per port hot reset requests
  always_comb begin
    rif.core_rst_n = rst_ok;
    for (int i = 0; i < NUM_DN; i++) begin
      rif.port_hot[i] = dn_sbr[i] || up_sbr ||
        (state == srp_pkg::SRP_HOT);
    end
  end

  srp_port #(.N(NUM_DN)) u_port (
    .clk(clk),
    .ce(ce),
    .rif(rif.port)
  );

  always_ff @(posedge clk) begin
    if (!rst_ok) begin
      core_reset_n <= 1'b0;
      hot_reset_n <= 1'b1;
      up_queue_flush <= 1'b1;
      dn_tx_hot_reset <= '0;
      dn_port_reset <= '1;
      dn_queue_drop <= '1;
      busy <= 1'b1;
    end else if (ce) begin
      core_reset_n <= 1'b1;
      // R5 R6 non-sticky reset only, clocks and config kept
      hot_reset_n <= !(state == srp_pkg::SRP_HOT);
      // R4 R15 drop every held packet on hot or upstream bus reset
      up_queue_flush <= (state == srp_pkg::SRP_HOT) || up_sbr;
      // R9 R13 training reset bit on links, not if disabled
      dn_tx_hot_reset <= rif.port_reset;
      dn_port_reset <= rif.port_reset;
      dn_queue_drop <= rif.port_drop;
      busy <= (state != srp_pkg::SRP_RUN) || load_pend;
    end
  end
endmodule

// ===== sim/srp_up_partner.sv
// Upstream link partner model
`timescale 1ns/100ps
module srp_up_partner (
  input wire logic clk,
  input wire logic req_hot,
  input wire logic req_down,
  output logic up_rx_hot_reset,
  output logic up_dl_inactive
);
  always_ff @(posedge clk) up_rx_hot_reset <= req_hot;
  // Link drops on command only
  always_ff @(posedge clk) up_dl_inactive <= req_down;
endmodule

// ===== sim/srp_monitor.sv
// Checker of reset propagation at the top ports
`timescale 1ns/100ps
module srp_checker #(parameter int NUM_DN = 4) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fundamental_reset_n,
  input wire logic up_rx_hot_reset,
  input wire logic up_dl_inactive,
  input wire logic [31:0] debug_control,
  input wire logic [31:0] up_bridge_control_word,
  input wire logic [NUM_DN-1:0] dn_sbr,
  input wire logic core_reset_n,
  input wire logic hot_reset_n,
  input wire logic up_queue_flush,
  input wire logic [NUM_DN-1:0] dn_tx_hot_reset,
  input wire logic [NUM_DN-1:0] dn_port_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic en = core_reset_n && !debug_control[20];
  AST_HOT_IN: assert property ($rose(up_rx_hot_reset) && en
    |-> ##[1:4] !hot_reset_n) else $error("no hot reset");
  AST_DL_DOWN: assert property ($rose(up_dl_inactive) && en
    |-> ##[1:4] !hot_reset_n) else $error("no link down reset");
  AST_DIS: assert property (core_reset_n && debug_control[20]
    && hot_reset_n |=> hot_reset_n) else $error("disable ignored");
  AST_FLUSH: assert property (!hot_reset_n |-> up_queue_flush)
    else $error("queues kept");
  AST_FWD: assert property ($fell(hot_reset_n)
    |-> ##[0:2] &dn_tx_hot_reset) else $error("not forwarded");
  AST_SBR: assert property ($rose(dn_sbr[0]) && core_reset_n
    |-> ##[1:3] dn_tx_hot_reset[0]) else $error("port not reset");
  AST_UP_SBR: assert property (
    $rose(up_bridge_control_word[22]) && core_reset_n |-> ##[1:3]
    &dn_port_reset && up_queue_flush && hot_reset_n)
    else $error("bus reset wrong");
  AST_FUND: assert property (!fundamental_reset_n
    |-> ##[1:3] !core_reset_n) else $error("no core reset");
endmodule
bind srp_top srp_checker #(.NUM_DN(NUM_DN)) chk (.clk(clk), .rst_n(rst_n),
  .fundamental_reset_n(fundamental_reset_n),
  .up_rx_hot_reset(up_rx_hot_reset), .up_dl_inactive(up_dl_inactive),
  .debug_control(debug_control),
  .up_bridge_control_word(up_bridge_control_word), .dn_sbr(dn_sbr),
  .core_reset_n(core_reset_n), .hot_reset_n(hot_reset_n),
  .up_queue_flush(up_queue_flush), .dn_tx_hot_reset(dn_tx_hot_reset),
  .dn_port_reset(dn_port_reset));

// ===== sim/tb.sv
// Self-checking bench of the reset propagation block
`timescale 1ns/100ps
module tb;
  logic clk = 0, rst_n = 0, fr_n = 1, rq_h = 0, rq_d = 0, rx, dl;
  logic core_n, hot_n, flush, load, bsy, mem = 1;
  logic [31:0] dbg = 0, bcw = 0;
  logic [3:0] sbr = 0, tx, prst, drop;
  int n_errors = 0, total_checks = 0, cyc = 0, loads = 0;
  initial forever #50 clk = ~clk;
  srp_up_partner up (.clk(clk), .req_hot(rq_h), .req_down(rq_d),
    .up_rx_hot_reset(rx), .up_dl_inactive(dl));
  srp_top uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .fundamental_reset_n(fr_n), .up_rx_hot_reset(rx), .up_dl_inactive(dl),
    .cfg_mem_present(mem), .debug_control(dbg),
    .up_bridge_control_word(bcw), .dn_sbr(sbr), .core_reset_n(core_n),
    .hot_reset_n(hot_n), .up_queue_flush(flush), .dn_tx_hot_reset(tx),
    .dn_port_reset(prst), .dn_queue_drop(drop), .cfg_load_start(load),
    .busy(bsy));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Hot reset from link; dis blocks it
  task automatic t_up(input bit down, input bit dis);
    // Let the previous call's release edge pass first
    wt(1);
    loads = 0;
    dbg[20] <= dis;
    if (down) rq_d <= 1;
    else rq_h <= 1;
    wt(6);
    chk(hot_n, dis);
    chk(tx, dis ? 4'h0 : 4'hf);
    chk(prst, dis ? 4'h0 : 4'hf);
    chk(flush, !dis);
    chk(bsy, !dis);
    rq_h <= 0;
    rq_d <= 0;
    wt(30);
    chk(hot_n, 1);
    chk(core_n, 1);
    chk(tx, 0);
    chk(bsy, 0);
    chk(loads[3:0], !dis);
    dbg[20] <= 0;
  endtask
  // One downstream bridge held in reset
  task automatic t_sbr;
    sbr <= 4'h1;
    wt(5);
    chk(tx, 4'h1);
    chk(drop, 4'h1);
    chk(hot_n, 1);
    wt(30);
    chk(prst, 4'h1);
    sbr <= 0;
    wt(6);
    chk(tx, 0);
  endtask
  // Upstream bridge bus reset
  task automatic t_upsbr;
    bcw <= 32'h0040_0000;
    wt(5);
    chk(prst, 4'hf);
    chk(tx, 4'hf);
    chk(flush, 1);
    chk(hot_n, 1);
    bcw <= 0;
    wt(30);
    chk(prst, 0);
  endtask
  // Warm reset mid-run
  task automatic t_warm(input bit m);
    loads = 0;
    mem <= m;
    fr_n <= 0;
    wt(5);
    chk(core_n, 0);
    chk(flush, 1);
    fr_n <= 1;
    wt(12);
    chk(core_n, 1);
    chk({flush, prst[2:0]}, 0);
    chk(loads[3:0], m);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (load === 1'b1) loads++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    wt(12);
    rst_n <= 1;
    wt(12);
    chk(core_n, 1);
    t_up(0, 0);
    t_up(1, 0);
    t_up(0, 1);
    t_up(1, 1);
    t_sbr;
    t_upsbr;
    t_warm(1);
    t_warm(0);
    print_verdict;
  end
endmodule
